// ---- bench/ssm_led_panel.sv ----
// Behavioural seven-segment panel that turns pin levels into lit lamps.
`timescale 1ns/1ps
`default_nettype none
module ssm_led_panel (
	// Pin levels from the scanner
	input wire logic [7:0] digit_drive,
	input wire logic [7:0] segment_drive,
	// How the panel is wired
	input wire logic dig_hi,
	input wire logic seg_hi,
	// Lamps that glow
	output logic [7:0] lit_digit,
	output logic [7:0] lit_seg
);
	// ---------------------------------------------------------------
	// Lamp logic
	// ---------------------------------------------------------------
	// A segment glows only while some common line is switched on.
	assign lit_digit = dig_hi ? digit_drive : ~digit_drive;
	assign lit_seg = (lit_digit == 8'h00) ? 8'h00 :
		(seg_hi ? segment_drive : ~segment_drive);
endmodule // ssm_led_panel
`default_nettype wire

// ---- bench/ssm_scan_mux_tb.sv ----
// Self-checking bench for the seven-segment scan multiplexer.
`timescale 1ns/1ps
`default_nettype none
module ssm_scan_mux_tb;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, lf_clk_pin, tick;
	logic [5:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [7:0] digit_drive, segment_drive, lit_digit, lit_seg;
	logic dig_hi, seg_hi;
	int mismatches = 0;
	int samples_checked = 0;
	int cycles = 0;
	int lfc = 0;
	int n;
	logic [7:0] mem_exp [8];
	localparam logic [6:0] GL [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f,
		7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f, 7'h77, 7'h7c,
		7'h39, 7'h5e, 7'h79, 7'h71};
	localparam int RATE_HZ [4] = '{500, 1000, 2000, 4000};
	localparam logic [1:0] OK = ssm_pkg::RESP_OKAY;

	ssm_scan_mux DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready),
		.lf_clk_pin(lf_clk_pin), .scan_advance_tick(tick),
		.digit_drive(digit_drive), .segment_drive(segment_drive));
	ssm_led_panel panel (.digit_drive(digit_drive),
		.segment_drive(segment_drive), .dig_hi(dig_hi), .seg_hi(seg_hi),
		.lit_digit(lit_digit), .lit_seg(lit_seg));

	// ---------------------------------------------------------------
	// Clocks and timeout
	// ---------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	// The slow source is sped up to keep the run short; only edges count.
	initial begin
		lf_clk_pin = 1'b0;
		forever #50 lf_clk_pin = ~lf_clk_pin;
	end
	always @(posedge lf_clk_pin) lfc++;
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			finish_test();
		end
	end

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got,
				exp);
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(negedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
		@(posedge aclk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(negedge aclk); while (bvalid !== 1'b1);
		chk({30'h0, bresp}, {30'h0, er}, "write response");
		@(posedge aclk);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] a, input logic [31:0] e,
		input logic [1:0] er, input string what);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge aclk); while (arready !== 1'b1);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (rvalid !== 1'b1);
		chk(rdata, e, what);
		chk({30'h0, rresp}, {30'h0, er}, what);
		@(posedge aclk);
		rready <= 1'b0;
	endtask

	task automatic setc(input logic dh, input logic sh, input logic [1:0] rt,
		input logic dm, input logic ti);
		wr(ssm_pkg::OFS_CTRL, {21'h0, 3'h7, 2'h0, ti, dm, rt, sh, dh}, OK);
		dig_hi = dh;
		seg_hi = sh;
		@(negedge aclk);
	endtask

	task automatic tick_n(input int k);
		repeat (k) begin
			@(posedge aclk);
			tick <= 1'b1;
			@(posedge aclk);
			tick <= 1'b0;
		end
		@(negedge aclk);
	endtask

	task automatic scan_chk(input int idx);
		chk(lit_digit, 8'h01 << idx, "lit digit");
		chk(lit_seg, mem_exp[idx], "lit segments");
	endtask

	task automatic mem_chk(input int d);
		rd(6'(32 + 4 * d), {24'h0, mem_exp[d]}, OK, "digit memory");
	endtask

	task automatic put_int(input int v, input int p, input int l);
		int k;
		wr(ssm_pkg::OFS_INT, 32'((l << 20) | (p << 16) | v), OK);
		for (k = l - 1; k >= 0; k--) begin
			if (p + k < 8) mem_exp[p + k] = {mem_exp[p + k][7], GL[v % 10]};
			v = v / 10;
		end
		repeat (20) @(posedge aclk);
	endtask

	task automatic measure(output int cnt);
		logic [7:0] m;
		int a;
		int k;
		for (int s = 0; s < 2; s++) begin
			m = lit_digit;
			k = 0;
			while (lit_digit === m && k < 5000) begin
				@(negedge aclk);
				k++;
			end
			if (s == 0) a = lfc;
			else cnt = lfc - a;
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", samples_checked,
			mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, tick} = 6'h00;
		awaddr = 6'h00;
		araddr = 6'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		{dig_hi, seg_hi} = 2'h0;
		foreach (mem_exp[d]) mem_exp[d] = 8'h00;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk(digit_drive, 8'hff, "idle digits");
		rd(ssm_pkg::OFS_CTRL, 32'h724, OK, "ctrl reset");
		rd(6'h18, 32'h0, ssm_pkg::RESP_SLVERR, "unmapped");
		wr(6'h20, 32'h55, ssm_pkg::RESP_SLVERR);
		setc(1'b0, 1'b0, 2'h3, 1'b0, 1'b0);
		wr(ssm_pkg::OFS_CMD, 32'h1, OK);
		@(negedge aclk);
		chk(digit_drive, 8'hfe, "first digit low");
		chk(segment_drive, 8'hff, "cleared blank");
		for (int v = 0; v < 16; v++) begin
			wr(ssm_pkg::OFS_HEX, 32'(((v % 8) << 8) | v), OK);
			mem_exp[v % 8] = {1'b0, GL[v]};
			mem_chk(v % 8);
		end
		wr(ssm_pkg::OFS_PAT, 32'h180, OK);
		mem_exp[1] = 8'h80;
		mem_chk(1);
		wr(ssm_pkg::OFS_DP, 32'h201, OK);
		mem_exp[2][7] = 1'b1;
		mem_chk(2);
		wr(ssm_pkg::OFS_DP, 32'h200, OK);
		mem_exp[2][7] = 1'b0;
		mem_chk(2);
		wr(ssm_pkg::OFS_DP, 32'h301, OK);
		wr(ssm_pkg::OFS_HEX, 32'h301, OK);
		mem_exp[3] = 8'h86;
		mem_chk(3);
		for (int i = 1; i <= 8; i++) begin
			tick_n(1);
			scan_chk(i % 8);
		end
		setc(1'b1, 1'b1, 2'h3, 1'b0, 1'b0);
		chk(digit_drive, 8'h01, "active high digit");
		chk(segment_drive, mem_exp[0], "active high segments");
		setc(1'b1, 1'b1, 2'h3, 1'b1, 1'b0);
		tick_n(1);
		chk(lit_digit, 8'h00, "dim dark");
		tick_n(1);
		scan_chk(1);
		tick_n(1);
		chk(lit_digit, 8'h00, "dim dark again");
		setc(1'b1, 1'b1, 2'h3, 1'b0, 1'b0);
		tick_n(1);
		scan_chk(2);
		put_int(65535, 0, 5);
		put_int(1234, 5, 2);
		for (int d = 0; d < 8; d++) mem_chk(d);
		wr(ssm_pkg::OFS_CMD, 32'h2, OK);
		@(negedge aclk);
		chk(digit_drive, 8'h00, "stopped");
		tick_n(2);
		chk(lit_digit, 8'h00, "stopped ticks");
		for (int r = 3; r >= 0; r--) begin
			setc(1'b1, 1'b1, 2'(r), 1'b0, 1'b1);
			wr(ssm_pkg::OFS_CMD, 32'h1, OK);
			measure(n);
			chk(32'(n), 32'(32000 / RATE_HZ[r]), "scan rate");
		end
		rd(6'h20, 32'h0, OK, "cleared memory");
		wr(ssm_pkg::OFS_CMD, 32'h2, OK);
		repeat (400) @(posedge aclk);
		chk(lit_digit, 8'h00, "timer stopped");
		finish_test();
	end
endmodule // ssm_scan_mux_tb
`default_nettype wire

// ---- hdl/ssm_bcd.sv ----
// Binary to five-digit decimal converter, shift and add-three.
`timescale 1ns/1ps
`default_nettype none
module ssm_bcd (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Request
	input wire logic start,
	input wire logic [15:0] value,
	// Result
	output logic busy,
	output logic done,
	output logic [19:0] digits
);
	logic [35:0] sh;
	logic [35:0] next_sh;
	logic [4:0] cnt;
	logic [4:0] next_cnt;
	logic next_busy;
	logic next_done;
	logic [19:0] adj;

	genvar g;
	generate
		for (g = 0; g < 5; g++) begin : g_adj
			assign adj[4*g+:4] = (sh[16+4*g+:4] >= 4'h5) ?
				4'(sh[16+4*g+:4] + 4'h3) : sh[16+4*g+:4];
		end
	endgenerate

	always_comb begin
		next_sh = sh;
		next_cnt = cnt;
		next_busy = busy;
		next_done = 1'b0;
		if (start && !busy) begin
			next_sh = {20'h0, value};
			next_cnt = 5'h0;
			next_busy = 1'b1;
		end else if (busy) begin
			next_sh = {adj, sh[15:0]} << 1;
			next_cnt = 5'(cnt + 5'h1);
			if (cnt == 5'(ssm_pkg::BCD_STEPS - 1)) begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sh <= 36'h0;
			cnt <= 5'h0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			sh <= next_sh;
			cnt <= next_cnt;
			busy <= next_busy;
			done <= next_done;
		end
	end

	assign digits = sh[35:16];
endmodule // ssm_bcd
`default_nettype wire

// ---- hdl/ssm_pkg.sv ----
// Constants, carriers and glyph table for the seven-segment scan multiplexer.
package ssm_pkg;

	// -------------------------------------------------------------------
	// Sizes and register map
	// -------------------------------------------------------------------
	localparam int NDIG = 8;
	localparam int AW = 6;
	localparam logic [AW-1:0] OFS_CTRL = 6'h00;
	localparam logic [AW-1:0] OFS_CMD = 6'h04;
	localparam logic [AW-1:0] OFS_HEX = 6'h08;
	localparam logic [AW-1:0] OFS_PAT = 6'h0c;
	localparam logic [AW-1:0] OFS_DP = 6'h10;
	localparam logic [AW-1:0] OFS_INT = 6'h14;
	localparam int MEM_SEL = 5;
	localparam int DIG_LSB = 8;
	localparam int CMD_START = 0;
	localparam int CMD_STOP = 1;
	localparam int INT_POS_LSB = 16;
	localparam int INT_LEN_LSB = 20;
	localparam logic [2:0] INT_MAX_LEN = 3'h5;
	localparam int BCD_STEPS = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// -------------------------------------------------------------------
	// Carriers
	// -------------------------------------------------------------------
	typedef struct packed {
		logic [2:0] last;
		logic [1:0] rsvd;
		logic timer_int;
		logic dim;
		logic [1:0] rate;
		logic seg_hi;
		logic dig_hi;
	} ssm_ctrl_t;
	localparam int CTRL_W = 11;
	localparam ssm_ctrl_t CTRL_RST = 11'h724;

	typedef struct packed {
		logic [15:0] value;
		logic [2:0] pos;
		logic [2:0] len;
	} ssm_int_req_t;

	// -------------------------------------------------------------------
	// Scan timing
	// -------------------------------------------------------------------
	localparam int LF_HZ = 32000;
	localparam int RATE0_HZ = 500;
	localparam int RATE1_HZ = 1000;
	localparam int RATE2_HZ = 2000;
	localparam int RATE3_HZ = 4000;
	localparam int DIV_W = 7;

	function automatic logic [DIV_W-1:0] rate_div(input logic [1:0] sel);
		case (sel)
			2'h0: rate_div = DIV_W'(LF_HZ / RATE0_HZ);
			2'h1: rate_div = DIV_W'(LF_HZ / RATE1_HZ);
			2'h2: rate_div = DIV_W'(LF_HZ / RATE2_HZ);
			default: rate_div = DIV_W'(LF_HZ / RATE3_HZ);
		endcase
	endfunction

	function automatic logic [6:0] glyph(input logic [3:0] v);
		case (v)
			4'h0: glyph = 7'h3f;
			4'h1: glyph = 7'h06;
			4'h2: glyph = 7'h5b;
			4'h3: glyph = 7'h4f;
			4'h4: glyph = 7'h66;
			4'h5: glyph = 7'h6d;
			4'h6: glyph = 7'h7d;
			4'h7: glyph = 7'h07;
			4'h8: glyph = 7'h7f;
			4'h9: glyph = 7'h6f;
			4'ha: glyph = 7'h77;
			4'hb: glyph = 7'h7c;
			4'hc: glyph = 7'h39;
			4'hd: glyph = 7'h5e;
			4'he: glyph = 7'h79;
			default: glyph = 7'h71;
		endcase
	endfunction

endpackage

// ---- hdl/ssm_scan_mux.sv ----
// Seven-segment scan multiplexer with AXI4-Lite control.
//
// Behaviour
// - digit enables follow selectable drive polarity
// - segment outputs follow their own polarity
// - four scan rates: 500, 1k, 2k, 4k
// - scan timer ticks from 32 kHz clock
// - start clears memory, starts scan, timer
// - stop halts scan, all digits inactive
// - hex store writes glyph to addressed digit
// - raw byte stored, one means lit
// - bit0 is segment a, bit7 point
// - point command changes only point bit
// - dim keeps every other tick dark
// - integer shown decimal, 1 to 5 digits
// - at most one digit lit at once
// - tick turns current off, next on
// - digit enables on consecutive output bits
// - position zero is leftmost, most significant
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ssm_scan_mux (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [ssm_pkg::AW-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [ssm_pkg::AW-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Timing sources
	input wire logic lf_clk_pin,
	input wire logic scan_advance_tick,
	// Display pins
	output logic [7:0] digit_drive,
	output logic [7:0] segment_drive
);
	// -------------------------------------------------------------------
	// State
	// -------------------------------------------------------------------
	ssm_pkg::ssm_ctrl_t ctrl;
	ssm_pkg::ssm_ctrl_t next_ctrl;
	ssm_pkg::ssm_int_req_t ireq;
	ssm_pkg::ssm_int_req_t next_ireq;
	logic [7:0] mem [ssm_pkg::NDIG];
	logic [7:0] next_mem [ssm_pkg::NDIG];
	logic running, next_running;
	logic timer_run, next_timer_run;
	logic phase, next_phase;
	logic [2:0] idx, next_idx;
	logic [ssm_pkg::DIV_W-1:0] div_cnt, next_div_cnt;
	logic lf_s1, lf_s2, lf_s3;
	logic next_bvalid, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic [7:0] next_digit, next_seg;
	logic [31:0] wmask, wd;
	logic wr_go, rd_go, stall, lf_edge, timer_tick, tick;
	logic sel_ctrl, sel_cmd, sel_hex, sel_pat, sel_dp, sel_int;
	logic do_start, do_stop;
	logic [2:0] wdig;
	logic [3:0] fend;
	logic bcd_busy, bcd_done;
	logic [19:0] bcd_digits;

	// -------------------------------------------------------------------
	// Bus write decode
	// -------------------------------------------------------------------
	genvar b;
	generate
		for (b = 0; b < 4; b++) begin : g_strb
			assign wmask[8*b+:8] = {8{wstrb[b]}};
		end
	endgenerate

	// Writes wait while a conversion is pending, so a render never races
	// a store into the same digit.
	assign stall = bcd_busy | bcd_done;
	assign wr_go = awvalid & wvalid & !bvalid & !stall;
	assign awready = wr_go;
	assign wready = wr_go;
	assign rd_go = arvalid & !rvalid;
	assign arready = rd_go;
	assign wd = wdata & wmask;
	assign wdig = wd[ssm_pkg::DIG_LSB+:3];
	assign sel_ctrl = wr_go && awaddr == ssm_pkg::OFS_CTRL;
	assign sel_cmd = wr_go && awaddr == ssm_pkg::OFS_CMD;
	assign sel_hex = wr_go && awaddr == ssm_pkg::OFS_HEX;
	assign sel_pat = wr_go && awaddr == ssm_pkg::OFS_PAT;
	assign sel_dp = wr_go && awaddr == ssm_pkg::OFS_DP;
	assign sel_int = wr_go && awaddr == ssm_pkg::OFS_INT;
	assign do_stop = sel_cmd & wd[ssm_pkg::CMD_STOP];
	assign do_start = sel_cmd & wd[ssm_pkg::CMD_START] & !do_stop;

	// -------------------------------------------------------------------
	// Bus answers
	// -------------------------------------------------------------------
	always_comb begin
		next_bvalid = bvalid & !bready;
		next_bresp = bresp;
		if (wr_go) begin
			next_bvalid = 1'b1;
			next_bresp = (sel_ctrl | sel_cmd | sel_hex | sel_pat | sel_dp |
				sel_int) ? ssm_pkg::RESP_OKAY : ssm_pkg::RESP_SLVERR;
		end
		next_rvalid = rvalid & !rready;
		next_rdata = rdata;
		next_rresp = rresp;
		if (rd_go) begin
			next_rvalid = 1'b1;
			next_rdata = 32'h0;
			next_rresp = ssm_pkg::RESP_OKAY;
			if (araddr[ssm_pkg::MEM_SEL] && araddr[1:0] == 2'h0)
				next_rdata = {24'h0, mem[araddr[4:2]]};
			else if (araddr == ssm_pkg::OFS_CTRL)
				next_rdata = {21'h0, ctrl};
			else if (araddr == ssm_pkg::OFS_CMD)
				next_rdata = {21'h0, idx, 5'h0, timer_run, stall, running};
			else if (araddr != ssm_pkg::OFS_HEX &&
				araddr != ssm_pkg::OFS_PAT && araddr != ssm_pkg::OFS_DP &&
				araddr != ssm_pkg::OFS_INT)
				next_rresp = ssm_pkg::RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= ssm_pkg::RESP_OKAY;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= ssm_pkg::RESP_OKAY;
		end else begin
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	// -------------------------------------------------------------------
	// Control and integer request
	// -------------------------------------------------------------------
	always_comb begin
		next_ctrl = ctrl;
		next_ireq = ireq;
		if (sel_ctrl) begin
			next_ctrl = (ctrl & ~wmask[ssm_pkg::CTRL_W-1:0]) |
				wd[ssm_pkg::CTRL_W-1:0];
			next_ctrl.rsvd = 2'h0;
		end
		if (sel_int) begin
			next_ireq.value = wd[15:0];
			next_ireq.pos = wd[ssm_pkg::INT_POS_LSB+:3];
			next_ireq.len = wd[ssm_pkg::INT_LEN_LSB+:3];
			if (next_ireq.len > ssm_pkg::INT_MAX_LEN)
				next_ireq.len = ssm_pkg::INT_MAX_LEN;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= ssm_pkg::CTRL_RST;
			ireq <= '0;
		end else begin
			ctrl <= next_ctrl;
			ireq <= next_ireq;
		end
	end

	ssm_bcd u_bcd (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(sel_int),
		.value(wd[15:0]),
		.busy(bcd_busy),
		.done(bcd_done),
		.digits(bcd_digits)
	);

	// -------------------------------------------------------------------
	// Digit memory
	// -------------------------------------------------------------------
	// Last position of the field, one bit wider so a field running past
	// the rightmost digit is simply cut short.
	assign fend = 4'({1'b0, ireq.pos} + {1'b0, ireq.len} - 4'h1);

	always_comb begin
		for (int d = 0; d < ssm_pkg::NDIG; d++) begin
			next_mem[d] = mem[d];
			if (do_start) begin
				next_mem[d] = 8'h0;
			end else if (bcd_done && ireq.len != 3'h0 &&
				4'(d) >= {1'b0, ireq.pos} && 4'(d) <= fend) begin
				next_mem[d][6:0] = ssm_pkg::glyph(
					bcd_digits[4*(3'(fend - 4'(d)))+:4]);
			end else if (sel_hex && wdig == 3'(d)) begin
				next_mem[d][6:0] = ssm_pkg::glyph(wd[3:0]);
			end else if (sel_pat && wdig == 3'(d)) begin
				next_mem[d] = wd[7:0];
			end else if (sel_dp && wdig == 3'(d)) begin
				next_mem[d][7] = wd[0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		for (int d = 0; d < ssm_pkg::NDIG; d++) begin
			if (!aresetn)
				mem[d] <= 8'h0;
			else
				mem[d] <= next_mem[d];
		end
	end

	// -------------------------------------------------------------------
	// Scan timer and scanner
	// -------------------------------------------------------------------
	// The 32 kHz pin is asynchronous; only its resynchronised copy is
	// edge-detected.
	assign lf_edge = lf_s2 & !lf_s3;

	always_comb begin
		next_div_cnt = div_cnt;
		timer_tick = 1'b0;
		if (!timer_run) begin
			next_div_cnt = '0;
		end else if (lf_edge) begin
			if (div_cnt >= 7'(ssm_pkg::rate_div(ctrl.rate) - 7'h1)) begin
				next_div_cnt = '0;
				timer_tick = 1'b1;
			end else begin
				next_div_cnt = 7'(div_cnt + 7'h1);
			end
		end
		tick = running & (ctrl.timer_int ? timer_tick : scan_advance_tick);
		next_running = running;
		next_timer_run = timer_run;
		next_idx = idx;
		next_phase = phase;
		if (do_stop) begin
			next_running = 1'b0;
			next_timer_run = 1'b0;
			next_phase = 1'b0;
		end else if (do_start) begin
			next_running = 1'b1;
			next_timer_run = ctrl.timer_int;
			next_idx = 3'h0;
			next_phase = 1'b0;
		end else if (tick) begin
			if (ctrl.dim && !phase) begin
				next_phase = 1'b1;
			end else begin
				next_phase = 1'b0;
				next_idx = (idx >= ctrl.last) ? 3'h0 : 3'(idx + 3'h1);
			end
		end
		next_digit = 8'h0;
		next_seg = 8'h0;
		if (next_running && !next_phase) begin
			next_digit = 8'h1 << next_idx;
			next_seg = next_mem[next_idx];
		end
		if (!next_ctrl.dig_hi)
			next_digit = ~next_digit;
		if (!next_ctrl.seg_hi)
			next_seg = ~next_seg;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lf_s1 <= 1'b0;
			lf_s2 <= 1'b0;
			lf_s3 <= 1'b0;
			div_cnt <= '0;
			running <= 1'b0;
			timer_run <= 1'b0;
			idx <= 3'h0;
			phase <= 1'b0;
			digit_drive <= 8'hff;
			segment_drive <= 8'hff;
		end else begin
			lf_s1 <= lf_clk_pin;
			lf_s2 <= lf_s1;
			lf_s3 <= lf_s2;
			div_cnt <= next_div_cnt;
			running <= next_running;
			timer_run <= next_timer_run;
			idx <= next_idx;
			phase <= next_phase;
			digit_drive <= next_digit;
			segment_drive <= next_seg;
		end
	end

	// -------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic lit;
	logic [7:0] dig_on;
	logic [6:0] lf_seen;
	assign lit = running & !phase;
	assign dig_on = ctrl.dig_hi ? digit_drive : ~digit_drive;

	always_ff @(posedge aclk) begin
		if (!aresetn || !timer_run || timer_tick)
			lf_seen <= 7'h0;
		else if (lf_edge)
			lf_seen <= 7'(lf_seen + 7'h1);
	end

	sequence s_dark;
		dig_on == 8'h0;
	endsequence

	property p_dig_pol;
		!lit |-> s_dark;
	endproperty
	a_dig_pol: assert property (p_dig_pol)
		else $error("dark digits not at inactive level");

	property p_one_digit;
		lit |-> $onehot(dig_on) && dig_on[idx];
	endproperty
	a_one_digit: assert property (p_one_digit)
		else $error("lit digit not single or not on its own pin");

	property p_seg;
		lit |-> segment_drive == (ctrl.seg_hi ? mem[idx] : ~mem[idx]);
	endproperty
	a_seg: assert property (p_seg)
		else $error("segment pins do not match stored pattern");

	property p_rate;
		timer_tick |-> lf_edge &&
			7'(lf_seen + 7'h1) == ssm_pkg::rate_div(ctrl.rate);
	endproperty
	a_rate: assert property (p_rate)
		else $error("scan tick spacing wrong");

	sequence s_started;
		running ##0 idx == 3'h0 ##0 mem[0] == 8'h0 ##0 mem[7] == 8'h0;
	endsequence

	property p_start;
		do_start |=> s_started ##0 timer_run == $past(ctrl.timer_int);
	endproperty
	a_start: assert property (p_start)
		else $error("start did not clear and run");

	property p_stop;
		do_stop |=> !running && !timer_run ##0 s_dark;
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop left display running");

	property p_advance;
		tick && !do_start && !do_stop && !ctrl.dim |=>
			idx == ($past(idx) >= $past(ctrl.last) ? 3'h0 :
			3'($past(idx) + 3'h1));
	endproperty
	a_advance: assert property (p_advance)
		else $error("scan did not move to next digit");

	property p_dim;
		tick && ctrl.dim && !phase && !do_start && !do_stop |=>
			s_dark ##0 idx == $past(idx);
	endproperty
	a_dim: assert property (p_dim)
		else $error("dim did not darken alternate tick");

	property p_hex;
		sel_hex && !do_start |=>
			mem[$past(wdig)] ==
			{$past(mem[wdig][7]), ssm_pkg::glyph($past(wd[3:0]))};
	endproperty
	a_hex: assert property (p_hex)
		else $error("hex store wrote wrong glyph");

	property p_dp;
		sel_dp |=> mem[$past(wdig)] ==
			{$past(wd[0]), $past(mem[wdig][6:0])};
	endproperty
	a_dp: assert property (p_dp)
		else $error("point command disturbed segments");

	property p_int;
		bcd_done && ireq.len != 3'h0 && fend < 4'h8 |=>
			mem[$past(fend[2:0])][6:0] ==
			ssm_pkg::glyph($past(bcd_digits[3:0]));
	endproperty
	a_int: assert property (p_int)
		else $error("integer units digit not at field end");
endmodule // ssm_scan_mux
`default_nettype wire
